// ---- design/blsd_map.svh ----
/*
 * named constants for the branch, load/store and literal decode core.
 * assumes inclusion by bare name from the core.
 */
`ifndef BLSD_MAP_SVH
`define BLSD_MAP_SVH
// ----------------------------------------
// primary opcodes
// ----------------------------------------
`define BLSD_OP_BRR 6'h26
`define BLSD_OP_BCR 6'h27
`define BLSD_OP_IMM 6'h2C
`define BLSD_OP_RET 6'h2D
`define BLSD_OP_BRL 6'h2E
`define BLSD_OP_BCL 6'h2F
`define BLSD_LOGIC_GRP 4'hA
`define BLSD_MEM_GRP 2'h3
// ----------------------------------------
// secondary field codes
// ----------------------------------------
`define BLSD_RT_SUB 5'h10
`define BLSD_RT_INT 5'h11
`define BLSD_RT_EXC 5'h12
`define BLSD_RT_BRK 5'h13
`define BLSD_BRK_CODE 5'h0C
`define BLSD_BF_DLY 4
`define BLSD_BF_ABS 3
`define BLSD_BF_LNK 2
`define BLSD_CC_EQ 3'h0
`define BLSD_CC_NE 3'h1
`define BLSD_CC_LT 3'h2
`define BLSD_CC_LE 3'h3
`define BLSD_CC_GT 3'h4
`define BLSD_CC_GE 3'h5
`define BLSD_SZ_BYTE 2'h0
`define BLSD_SZ_HALF 2'h1
`define BLSD_SZ_WORD 2'h2
// ----------------------------------------
// status word bit positions (bit 0 is lsb)
// ----------------------------------------
`define BLSD_MSR_EIP 9
`define BLSD_MSR_EE 8
`define BLSD_MSR_BIP 3
`define BLSD_MSR_IE 1
`define BLSD_MSR_RST 32'h0000_0000
`define BLSD_ESR_RST 32'h0000_0000
`define BLSD_ESR_EXT 32'h0000_0001
// ----------------------------------------
// link registers, vectors, steps
// ----------------------------------------
`define BLSD_REG_ZERO 5'h00
`define BLSD_LINK_INT 5'h0E
`define BLSD_LINK_BRK 5'h10
`define BLSD_LINK_EXC 5'h11
`define BLSD_VEC_RST 32'h0000_0000
`define BLSD_VEC_INT 32'h0000_0010
`define BLSD_VEC_BRK 32'h0000_0018
`define BLSD_VEC_EXC 32'h0000_0020
`define BLSD_PC_STEP 32'h0000_0004
`define BLSD_WORD_ZERO 32'h0000_0000
`endif

// ---- design/blsd_pkg.sv ----
/*
 * types shared by the decode core: states and bus request carriers.
 * assumes blsd_map.svh is on the include path.
 */
package blsd_pkg;
// ----------------------------------------
// sequencer states and bus carriers
// ----------------------------------------
typedef enum logic [1:0] {st_check, st_fetch, st_exec, st_mem} blsd_state_t;
typedef struct packed {
    logic req;
    logic [31:0] addr;
} blsd_ireq_t;
typedef struct packed {
    logic req;
    logic we;
    logic [3:0] sel;
    logic [31:0] addr;
    logic [31:0] wdata;
} blsd_dreq_t;
endpackage

// ---- design/blsd_core.sv ----
/*
 * multi-cycle core executing branches, returns, literal logic ops and
 * byte/half/word loads and stores, with its 32-entry register file.
 * assumes request/ack buses on core_clk; event pins are asynchronous.
 */
// Contract
// - return codes jump; interrupt return sets enable
// - exception return: enable, clear progress, clear status
// - break return jumps, clears break-in-progress
// - break literal: absolute jump, link, set break
// - relative literal jumps, delayed, delayed with link
// - absolute literal jumps, delayed, delayed with link
// - literal conditional branch on six signed tests
// - register-offset greater tests add second source
// - or, and, xor, and-not with literal
// - byte load into low byte, rest zero
// - half load into low half, rest zero
// - word load writes whole word
// - byte store writes low data byte
// - half store writes low data half
// - word store writes whole data register
// - literal sign-extended from low sixteen bits
// - thirty-two registers of 32 bits
// - register zero reads zero, writes dropped
// - register file untouched by reset
// - interrupt links r14, break links r16
// - exception links r17 when option built
// - status bits at 1, 3, 8, 9
`timescale 1ns/100ps
`include "blsd_map.svh"
module blsd_core
    import blsd_pkg::*;
#(
    parameter bit HW_EXC = 1'b1
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    output blsd_ireq_t ibus_req,
    input wire logic ibus_ack,
    input wire logic [31:0] ibus_rdata,
    output blsd_dreq_t dbus_req,
    input wire logic dbus_ack,
    input wire logic [31:0] dbus_rdata,
    input wire logic irq_pin,
    input wire logic brk_pin,
    input wire logic exc_pin,
    output logic [31:0] machine_status,
    output logic [31:0] exception_status
);
// ----------------------------------------
// helpers
// ----------------------------------------
// signed test of one value against zero
function automatic logic blsd_cond(input logic [31:0] v, input logic [2:0] c);
    logic z;
    z = (v == `BLSD_WORD_ZERO);
    case (c)
        `BLSD_CC_EQ: blsd_cond = z;
        `BLSD_CC_NE: blsd_cond = !z;
        `BLSD_CC_LT: blsd_cond = v[31];
        `BLSD_CC_LE: blsd_cond = v[31] || z;
        `BLSD_CC_GT: blsd_cond = !v[31] && !z;
        `BLSD_CC_GE: blsd_cond = !v[31];
        default: blsd_cond = 1'b0;
    endcase
endfunction
// byte lanes, big-endian: address 0 is the top lane
function automatic logic [3:0] blsd_sel(input logic [1:0] sz, input logic [1:0] a);
    case (sz)
        `BLSD_SZ_BYTE: blsd_sel = 4'h8 >> a;
        `BLSD_SZ_HALF: blsd_sel = a[1] ? 4'h3 : 4'hC;
        default: blsd_sel = 4'hF;
    endcase
endfunction
// pull the addressed item out of a read word, zero filled
function automatic logic [31:0] blsd_pick(input logic [1:0] sz, input logic [1:0] a,
                                          input logic [31:0] w);
    logic [7:0] b;
    logic [15:0] h;
    b = w[8'(5'd31 - {a, 3'h0}) -: 8];
    h = a[1] ? w[15:0] : w[31:16];
    case (sz)
        `BLSD_SZ_BYTE: blsd_pick = {24'h0, b};
        `BLSD_SZ_HALF: blsd_pick = {16'h0, h};
        default: blsd_pick = w;
    endcase
endfunction
// ----------------------------------------
// state
// ----------------------------------------
blsd_state_t state_reg; // sequencer
logic [31:0] pc_reg; // address of executing instruction
logic [31:0] instr_reg; // fetched word
logic dly_valid_reg; // a delayed transfer waits on its slot
logic [31:0] dly_target_reg; // where it goes
logic imm_valid_reg; // prefix pending
logic [15:0] imm_hold_reg; // prefix upper half
logic [31:0] msr_reg; // status word, only four bits live
logic [31:0] esr_reg; // exception status
logic [2:0] pin_meta_reg; // first stage, read by second only
logic [2:0] pin_sync_reg; // irq, brk, exc
logic [31:0] gpr [32]; // register file, no reset
// ----------------------------------------
// decode
// ----------------------------------------
logic [5:0] opc;
logic [4:0] fd, fa, fb;
logic [15:0] imm16;
logic [31:0] ra_val, rb_val, rd_val, lit, opb, sum_a;
logic is_brf, is_bc, is_ret, is_logic, is_mem, is_brk;
assign opc = instr_reg[31:26];
assign fd = instr_reg[25:21];
assign fa = instr_reg[20:16];
assign fb = instr_reg[15:11];
assign imm16 = instr_reg[15:0];
assign ra_val = gpr[fa];
assign rb_val = gpr[fb];
assign rd_val = gpr[fd];
// prefix replaces sign extension for one instruction
assign lit = imm_valid_reg ? {imm_hold_reg, imm16}
                           : {{16{imm16[15]}}, imm16};
// opcode bit 2 (lsb index 3) picks literal over second source
assign opb = opc[3] ? lit : rb_val;
assign sum_a = ra_val + opb;
assign is_brf = (opc == `BLSD_OP_BRR) || (opc == `BLSD_OP_BRL);
assign is_bc = (opc == `BLSD_OP_BCR) || (opc == `BLSD_OP_BCL);
assign is_ret = (opc == `BLSD_OP_RET);
assign is_logic = (opc[5:2] == `BLSD_LOGIC_GRP);
// size code 11 is not a memory op here; it falls through as a no-op
assign is_mem = (opc[5:4] == `BLSD_MEM_GRP) && (opc[1:0] != 2'h3);
assign is_brk = is_brf && (fa == `BLSD_BRK_CODE);
// ----------------------------------------
// transfer resolution
// ----------------------------------------
logic jmp_take, jmp_dly, bc_take;
logic [31:0] jmp_tgt, logic_res;
assign bc_take = blsd_cond(ra_val, fd[2:0]);
// combinational pick of target and delay for the current word
always_comb
begin
    jmp_take = 1'b0;
    jmp_dly = 1'b0;
    jmp_tgt = pc_reg + opb;
    if (is_brf)
    begin
        // absolute or relative, delay bit from the source field
        jmp_take = 1'b1;
        jmp_dly = fa[`BLSD_BF_DLY];
        jmp_tgt = fa[`BLSD_BF_ABS] ? opb : pc_reg + opb;
    end
    else if (is_bc)
    begin
        // always relative; leading code bit selects delayed
        jmp_take = bc_take;
        jmp_dly = fd[`BLSD_BF_DLY];
    end
    else if (is_ret)
    begin
        // every return form is delayed
        jmp_take = 1'b1;
        jmp_dly = 1'b1;
        jmp_tgt = sum_a;
    end
end
// logical ops against the literal operand
always_comb
begin
    case (opc[1:0])
        2'h0: logic_res = ra_val | opb;
        2'h1: logic_res = ra_val & opb;
        2'h2: logic_res = ra_val ^ opb;
        default: logic_res = ra_val & ~opb;
    endcase
end
// ----------------------------------------
// event pins and trap choice
// ----------------------------------------
logic irq_s, brk_s, exc_s, can_trap, take_exc, take_brk, take_int, trap;
// two-stage synchroniser for all three pins
always_ff @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        pin_meta_reg <= 3'h0;
        pin_sync_reg <= 3'h0;
    end
    else
    begin
        pin_meta_reg <= {exc_pin, brk_pin, irq_pin};
        pin_sync_reg <= pin_meta_reg;
    end
end
assign irq_s = pin_sync_reg[0];
assign brk_s = pin_sync_reg[1];
assign exc_s = pin_sync_reg[2];
// never split a delayed pair or a prefix from its user
assign can_trap = (state_reg == st_check) && !dly_valid_reg && !imm_valid_reg;
assign take_exc = HW_EXC && exc_s && msr_reg[`BLSD_MSR_EE] && !msr_reg[`BLSD_MSR_EIP];
assign take_brk = brk_s && !msr_reg[`BLSD_MSR_BIP];
assign take_int = irq_s && msr_reg[`BLSD_MSR_IE];
assign trap = can_trap && (take_exc || take_brk || take_int);
// ----------------------------------------
// sequencer and program counter
// ----------------------------------------
always_ff @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        state_reg <= st_check;
        pc_reg <= `BLSD_VEC_RST;
        instr_reg <= `BLSD_WORD_ZERO;
        dly_valid_reg <= 1'b0;
        dly_target_reg <= `BLSD_WORD_ZERO;
    end
    else
    begin
        case (state_reg)
            st_check:
            begin
                // exception beats break beats interrupt
                if (trap)
                    pc_reg <= take_exc ? `BLSD_VEC_EXC : take_brk ? `BLSD_VEC_BRK
                                                                 : `BLSD_VEC_INT;
                else
                    state_reg <= st_fetch;
            end
            st_fetch:
            begin
                if (ibus_ack)
                begin
                    instr_reg <= ibus_rdata;
                    state_reg <= st_exec;
                end
            end
            st_exec:
            begin
                if (is_mem)
                    state_reg <= st_mem;
                else
                begin
                    state_reg <= st_check;
                    if (dly_valid_reg)
                    begin
                        // slot done; a jump in the slot is ignored
                        pc_reg <= dly_target_reg;
                        dly_valid_reg <= 1'b0;
                    end
                    else if (jmp_take && jmp_dly)
                    begin
                        pc_reg <= pc_reg + `BLSD_PC_STEP;
                        dly_valid_reg <= 1'b1;
                        dly_target_reg <= jmp_tgt;
                    end
                    else if (jmp_take)
                        pc_reg <= jmp_tgt;
                    else
                        pc_reg <= pc_reg + `BLSD_PC_STEP;
                end
            end
            st_mem:
            begin
                if (dbus_ack)
                begin
                    state_reg <= st_check;
                    pc_reg <= dly_valid_reg ? dly_target_reg : pc_reg + `BLSD_PC_STEP;
                    dly_valid_reg <= 1'b0;
                end
            end
            default: state_reg <= st_check;
        endcase
    end
end
// ----------------------------------------
// instruction and data bus requests
// ----------------------------------------
// fetch request holds until acknowledged
always_ff @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
        ibus_req <= '0;
    else if ((state_reg == st_check) && !trap)
    begin
        ibus_req.req <= 1'b1;
        ibus_req.addr <= pc_reg;
    end
    else if ((state_reg == st_fetch) && ibus_ack)
        ibus_req.req <= 1'b0;
end
// data request; store data replicated over every lane
always_ff @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
        dbus_req <= '0;
    else if ((state_reg == st_exec) && is_mem)
    begin
        dbus_req.req <= 1'b1;
        dbus_req.we <= opc[2];
        dbus_req.addr <= sum_a;
        dbus_req.sel <= blsd_sel(opc[1:0], sum_a[1:0]);
        case (opc[1:0])
            `BLSD_SZ_BYTE: dbus_req.wdata <= {4{rd_val[7:0]}};
            `BLSD_SZ_HALF: dbus_req.wdata <= {2{rd_val[15:0]}};
            default: dbus_req.wdata <= rd_val;
        endcase
    end
    else if ((state_reg == st_mem) && dbus_ack)
        dbus_req.req <= 1'b0;
end
// ----------------------------------------
// status word and exception status
// ----------------------------------------
always_ff @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        msr_reg <= `BLSD_MSR_RST;
        esr_reg <= `BLSD_ESR_RST;
    end
    else if (trap)
    begin
        // entry masks further events of the same kind
        if (take_exc)
        begin
            msr_reg[`BLSD_MSR_EIP] <= 1'b1;
            msr_reg[`BLSD_MSR_EE] <= 1'b0;
            esr_reg <= `BLSD_ESR_EXT;
        end
        else if (take_brk)
            msr_reg[`BLSD_MSR_BIP] <= 1'b1;
        else
            msr_reg[`BLSD_MSR_IE] <= 1'b0;
    end
    else if ((state_reg == st_exec) && !dly_valid_reg)
    begin
        if (is_brk)
            msr_reg[`BLSD_MSR_BIP] <= 1'b1;
        else if (is_ret)
        begin
            case (fd)
                `BLSD_RT_INT: msr_reg[`BLSD_MSR_IE] <= 1'b1;
                `BLSD_RT_EXC:
                begin
                    msr_reg[`BLSD_MSR_EE] <= 1'b1;
                    msr_reg[`BLSD_MSR_EIP] <= 1'b0;
                    esr_reg <= `BLSD_ESR_RST;
                end
                `BLSD_RT_BRK: msr_reg[`BLSD_MSR_BIP] <= 1'b0;
                default: msr_reg <= msr_reg;
            endcase
        end
    end
end
assign machine_status = msr_reg;
assign exception_status = esr_reg;
// ----------------------------------------
// literal prefix
// ----------------------------------------
always_ff @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        imm_valid_reg <= 1'b0;
        imm_hold_reg <= 16'h0;
    end
    else if ((state_reg == st_exec) && (opc == `BLSD_OP_IMM))
    begin
        imm_valid_reg <= 1'b1;
        imm_hold_reg <= imm16;
    end
    else if (((state_reg == st_exec) && !is_mem) || ((state_reg == st_mem) && dbus_ack))
        imm_valid_reg <= 1'b0; // consumed by exactly one instruction
end
// ----------------------------------------
// register file
// ----------------------------------------
logic gpr_we;
logic [4:0] gpr_wa;
logic [31:0] gpr_wd;
// one write port: trap link, alu/link result or load data
always_comb
begin
    gpr_we = 1'b0;
    gpr_wa = fd;
    gpr_wd = pc_reg;
    if (trap)
    begin
        gpr_we = 1'b1;
        gpr_wa = take_exc ? `BLSD_LINK_EXC
                          : take_brk ? `BLSD_LINK_BRK : `BLSD_LINK_INT;
    end
    else if ((state_reg == st_exec) && !dly_valid_reg && is_brf && fa[`BLSD_BF_LNK])
        gpr_we = 1'b1;
    else if ((state_reg == st_exec) && is_logic)
    begin
        gpr_we = 1'b1;
        gpr_wd = logic_res;
    end
    else if ((state_reg == st_mem) && dbus_ack && !opc[2])
    begin
        gpr_we = 1'b1;
        gpr_wd = blsd_pick(opc[1:0], dbus_req.addr[1:0], dbus_rdata);
    end
end
// zero at configuration load only; reset never reaches it
initial
begin
    for (int i = 0; i < 32; i++)
        gpr[i] = `BLSD_WORD_ZERO;
end
always_ff @(posedge core_clk)
begin
    if (gpr_we && (gpr_wa != `BLSD_REG_ZERO))
        gpr[gpr_wa] <= gpr_wd;
end
// ----------------------------------------
// checks
// ----------------------------------------
logic ex_now;
assign ex_now = (state_reg == st_exec) && !dly_valid_reg;
property p_r0_zero;
    @(posedge core_clk) disable iff (!arst_n) gpr[0] == `BLSD_WORD_ZERO;
endproperty
a_r0_zero: assert property (p_r0_zero) else $error("r0 not zero");
property p_int_ret;
    @(posedge core_clk) disable iff (!arst_n)
    (ex_now && is_ret && fd == `BLSD_RT_INT) |=> machine_status[`BLSD_MSR_IE] && dly_valid_reg;
endproperty
a_int_ret: assert property (p_int_ret) else $error("int return");
property p_exc_ret;
    @(posedge core_clk) disable iff (!arst_n) (ex_now && is_ret && fd == `BLSD_RT_EXC)
    |=> machine_status[`BLSD_MSR_EE] && !machine_status[`BLSD_MSR_EIP]
        && exception_status == `BLSD_ESR_RST;
endproperty
a_exc_ret: assert property (p_exc_ret) else $error("exc return");
property p_brk_ret;
    @(posedge core_clk) disable iff (!arst_n)
    (ex_now && is_ret && fd == `BLSD_RT_BRK) |=> !machine_status[`BLSD_MSR_BIP];
endproperty
a_brk_ret: assert property (p_brk_ret) else $error("brk return");
property p_brk_lit;
    @(posedge core_clk) disable iff (!arst_n) (ex_now && is_brk && opc[3])
    |=> pc_reg == $past(lit) && machine_status[`BLSD_MSR_BIP];
endproperty
a_brk_lit: assert property (p_brk_lit) else $error("brk literal");
property p_cond;
    @(posedge core_clk) disable iff (!arst_n) (ex_now && is_bc && bc_take && !fd[4])
    |=> pc_reg == $past(pc_reg) + $past(opb);
endproperty
a_cond: assert property (p_cond) else $error("cond branch");
property p_logic;
    @(posedge core_clk) disable iff (!arst_n) (state_reg == st_exec && is_logic && fd != 5'h0)
    |=> gpr[$past(fd)] == $past(logic_res);
endproperty
a_logic: assert property (p_logic) else $error("logic result");
property p_byte_ld;
    @(posedge core_clk) disable iff (!arst_n) (state_reg == st_mem && dbus_ack && !opc[2]
    && opc[1:0] == `BLSD_SZ_BYTE && fd != 5'h0) |=> gpr[$past(fd)][31:8] == 24'h0;
endproperty
a_byte_ld: assert property (p_byte_ld) else $error("byte load");
property p_word_st;
    @(posedge core_clk) disable iff (!arst_n) (state_reg == st_exec && is_mem && opc[2]
    && opc[1:0] == `BLSD_SZ_WORD) |=> dbus_req.sel == 4'hF && dbus_req.wdata == $past(rd_val);
endproperty
a_word_st: assert property (p_word_st) else $error("word store");
property p_imm;
    @(posedge core_clk) disable iff (!arst_n) (state_reg == st_exec && opc == `BLSD_OP_IMM)
    |=> imm_valid_reg && imm_hold_reg == $past(imm16);
endproperty
a_imm: assert property (p_imm) else $error("prefix");
property p_int_link;
    @(posedge core_clk) disable iff (!arst_n) (trap && !take_exc && !take_brk)
    |=> gpr[14] == $past(pc_reg) && !machine_status[`BLSD_MSR_IE];
endproperty
a_int_link: assert property (p_int_link) else $error("int link");
endmodule

// ---- tb/blsd_mem_model.sv ----
/*
 * word memory answering the core's fetch and data requests.
 * assumes the core holds each request until the edge that sees its ack.
 */
`timescale 1ns/100ps
module blsd_mem_model
    import blsd_pkg::*;
(
    input wire logic core_clk,
    input wire blsd_ireq_t ibus_req,
    output logic ibus_ack,
    output logic [31:0] ibus_rdata,
    input wire blsd_dreq_t dbus_req,
    output logic dbus_ack,
    output logic [31:0] dbus_rdata
);
    // ----------------------------------------
    // storage and pacing
    // ----------------------------------------
    logic [31:0] mem [0:255]; // preloaded by the bench
    logic [1:0] iwait; // cycles left before a fetch answer
    logic [1:0] dwait; // cycles left before a data answer
    logic itog; // alternates prompt and slow answers
    logic dtog;
    initial
    begin
        {ibus_ack, dbus_ack, iwait, dwait, itog, dtog} = 8'h00;
        ibus_rdata = 32'h0000_0000;
        dbus_rdata = 32'h0000_0000;
    end
    // fetch: word valid only with ack, churned otherwise so stale data shows
    always @(posedge core_clk)
    begin
        ibus_ack <= 1'b0;
        ibus_rdata <= ~ibus_rdata;
        if (ibus_req.req && !ibus_ack)
        begin
            if (iwait == 2'h0)
            begin
                ibus_ack <= 1'b1;
                ibus_rdata <= mem[ibus_req.addr[9:2]];
                iwait <= {itog, 1'b0};
                itog <= ~itog;
            end
            else
                iwait <= iwait - 2'h1;
        end
    end
    // data: lane writes by select, big-endian lanes as the core drives them
    always @(posedge core_clk)
    begin
        dbus_ack <= 1'b0;
        dbus_rdata <= ~dbus_rdata;
        if (dbus_req.req && !dbus_ack)
        begin
            if (dwait == 2'h0)
            begin
                dbus_ack <= 1'b1;
                dbus_rdata <= mem[dbus_req.addr[9:2]];
                for (int b = 0; b < 4; b++)
                    if (dbus_req.we && dbus_req.sel[b])
                        mem[dbus_req.addr[9:2]][8*b+:8] <= dbus_req.wdata[8*b+:8];
                dwait <= {1'b0, dtog};
                dtog <= ~dtog;
            end
            else
                dwait <= dwait - 2'h1;
        end
    end
endmodule

// ---- tb/branch_loadstore_decode_tb.sv ----
/*
 * program-driven bench: loads code into the memory model, runs it,
 * then checks stored register images and the status outputs.
 * assumes brk and exc pins stay quiet; irq is raised in the last phase.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end
module branch_loadstore_decode_tb
    import blsd_pkg::*;
    ;
    // ----------------------------------------
    // wiring
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic arst_n = 1'b0; // held low from time zero
    logic irq = 1'b0; // interrupt request, raised in the last phase
    blsd_ireq_t ibus_req;
    blsd_dreq_t dbus_req;
    logic ibus_ack, dbus_ack;
    logic [31:0] ibus_rdata, dbus_rdata, machine_status, exception_status;
    int err_total = 0, total_checks = 0, pw, n;
    // register images after the run, r0 to r11
    logic [31:0] exp_r [0:11] = '{32'h0, 32'hFFFF8001, 32'h1, 32'h7FFE, 32'hFFFF8000,
        32'h80, 32'h8001, 32'hFFFF8001, 32'h28, 32'h1, 32'h7, 32'h3C};
    blsd_core i_blsd_core (.core_clk(core_clk), .arst_n(arst_n), .ibus_req(ibus_req),
        .ibus_ack(ibus_ack), .ibus_rdata(ibus_rdata), .dbus_req(dbus_req),
        .dbus_ack(dbus_ack), .dbus_rdata(dbus_rdata), .irq_pin(irq), .brk_pin(1'b0),
        .exc_pin(1'b0), .machine_status(machine_status),
        .exception_status(exception_status));
    blsd_mem_model i_blsd_mem_model (.core_clk(core_clk), .ibus_req(ibus_req),
        .ibus_ack(ibus_ack), .ibus_rdata(ibus_rdata), .dbus_req(dbus_req),
        .dbus_ack(dbus_ack), .dbus_rdata(dbus_rdata));
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task p(input logic [5:0] op, input logic [4:0] rd, ra, input logic [15:0] im);
        i_blsd_mem_model.mem[pw] = {op, rd, ra, im};
        pw++;
    endtask
    // bounded wait on a memory word leaving its sentinel
    task wait_word(input int a);
        for (n = 0; n < 4000 && i_blsd_mem_model.mem[a] === 32'hA5A5_A5A5; n++)
            @(posedge core_clk);
        if (n == 4000)
            err_total++;
        if (n == 4000)
            conclude();
    endtask
    task conclude;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------
    // program and checks
    // ----------------------------------------
    initial
    begin
        for (int i = 0; i < 256; i++)
            i_blsd_mem_model.mem[i] = 32'hA5A5_A5A5;
        i_blsd_mem_model.mem[65] = 32'h0000_0000;
        pw = 0;
        p(6'h28, 5'h01, 5'h00, 16'h8001);
        p(6'h29, 5'h02, 5'h01, 16'h00FF);
        p(6'h2A, 5'h03, 5'h01, 16'hFFFF);
        p(6'h2B, 5'h04, 5'h01, 16'h000F);
        p(6'h3E, 5'h01, 5'h00, 16'h0100);
        p(6'h38, 5'h05, 5'h00, 16'h0102);
        p(6'h39, 5'h06, 5'h00, 16'h0102);
        p(6'h3A, 5'h07, 5'h00, 16'h0100);
        p(6'h3C, 5'h02, 5'h00, 16'h0104);
        p(6'h28, 5'h00, 5'h00, 16'h0005);
        p(6'h2E, 5'h08, 5'h14, 16'h000C);
        p(6'h28, 5'h09, 5'h00, 16'h0001);
        p(6'h28, 5'h09, 5'h00, 16'h0002);
        p(6'h2F, 5'h00, 5'h00, 16'h0008);
        p(6'h28, 5'h0A, 5'h00, 16'h0003);
        p(6'h2E, 5'h0B, 5'h0C, 16'h0048);
        pw = 18;
        p(6'h2D, 5'h11, 5'h00, 16'h0054);
        p(6'h28, 5'h0A, 5'h00, 16'h0007);
        p(6'h28, 5'h0A, 5'h00, 16'h0009);
        for (int k = 0; k < 12; k++)
            p(6'h3E, k[4:0], 5'h00, 16'(16'h0140 + 4 * k));
        p(6'h2E, 5'h00, 5'h08, 16'h0084);
        repeat (12) @(posedge core_clk);
        #2 arst_n = 1'b1;
        wait_word(91);
        repeat (4) @(posedge core_clk);
        #2;
        for (int k = 0; k < 12; k++)
            `CHK("reg image", exp_r[k], i_blsd_mem_model.mem[80 + k])
        `CHK("word store", 32'hFFFF8001, i_blsd_mem_model.mem[64])
        `CHK("byte store", 32'h0100_0000, i_blsd_mem_model.mem[65])
        `CHK("status", 32'h0000_000A, machine_status)
        `CHK("exc status", 32'h0000_0000, exception_status)
        // second reset: status clears, registers must survive it
        #2 arst_n = 1'b0;
        @(posedge core_clk);
        #2;
        `CHK("status reset", 32'h0000_0000, machine_status)
        pw = 0;
        p(6'h3E, 5'h07, 5'h00, 16'h0180);
        // interrupt return enables, then idle loop at 0x8 awaits the pin
        p(6'h2D, 5'h11, 5'h00, 16'h0008);
        p(6'h2E, 5'h00, 5'h08, 16'h0008);
        pw = 4;
        p(6'h3E, 5'h0E, 5'h00, 16'h0190);
        p(6'h2E, 5'h00, 5'h08, 16'h0014);
        arst_n = 1'b1;
        wait_word(96);
        `CHK("reg kept", 32'hFFFF8001, i_blsd_mem_model.mem[96])
        #2 irq = 1'b1;
        wait_word(100);
        #2;
        `CHK("int link", 32'h0000_0008, i_blsd_mem_model.mem[100])
        `CHK("int masked", 32'h0000_0000, machine_status)
        conclude();
    end
endmodule
